//--- tvr_readout.sv
// Temperature value readout: three signed channels behind a byte register port.
// Assumes the conversion engine delivers results with a one-cycle valid pulse,
// and that the filter enables come from the filter setting logic elsewhere.
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps

// How it works
// - Reading a channel's integer byte captures its fraction byte into a hold latch.
// - Reading the held fraction byte releases the hold back to live data.
// - Each further integer read recaptures the fraction, overwriting any unread held value.
// - Local integer byte is two's complement, sign in bit 7, 64 down to 1.
// - Local fraction byte at 0x20 carries half, quarter, eighth in bits 7 to 5.
// - Unused fraction bits always read zero: local 4-0, remote 2-0.
// - Local temperature value is what decides the local over-temperature event.
// - Remote integer bytes at 0x11 and 0x12 are signed, 64 down to 1.
// - Remote fraction bytes at 0x21 and 0x22 carry half, quarter, eighth in 7-5.
// - Remote fraction bit 4 is zero with filter off when captured or read live, one sixteenth with it on.
// - Remote fraction bit 3 is zero with filter off when captured or read live, one thirty-second with it on.
module tvr_readout
    import tvr_pkg::*;
(
    // Clock, reset and enable
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Conversion results, index 0 local, 1 and 2 remote
    input wire logic [NUM_CH-1:0] conv_valid,
    input wire logic [NUM_CH-1:0][INT_W-1:0] conv_int,
    input wire logic [NUM_CH-1:0][FRAC_W-1:0] conv_frac,
    // Digital filter enables of the remote channels
    input wire logic [1:0] remote_filt_on,
    // Local over-temperature decision
    output logic local_alarm
);

    // ******************************************************************
    // Declarations
    // ******************************************************************
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] limit_ff;
    logic [7:0] nxt_limit;
    logic alarm_q;
    logic alarm_ff;
    logic [NUM_CH-1:0] filt_vec;
    logic [NUM_CH-1:0] rd_hi;
    logic [NUM_CH-1:0] rd_lo;
    logic [NUM_CH-1:0] held_vec;
    logic [NUM_CH-1:0][7:0] hi_bytes;
    logic [NUM_CH-1:0][7:0] lo_bytes;
    logic [NUM_CH-1:0][7:0] hi_ofs;
    logic [NUM_CH-1:0][7:0] lo_ofs;
    logic hit_limit;
    logic hit_status;
    logic wr_limit;
    logic [7:0] status_byte;

    // ******************************************************************
    // Address map
    // ******************************************************************

    // Offsets gathered per channel so the decode can run in one loop.
    assign hi_ofs[CH_LOCAL] = OFS_LOCAL_TEMP_INTEGER;
    assign hi_ofs[CH_REMOTE1] = OFS_REMOTE_ONE_SIGNED_INTEGER;
    assign hi_ofs[CH_REMOTE2] = OFS_REMOTE_TWO_SIGNED_INTEGER;
    assign lo_ofs[CH_LOCAL] = OFS_LOCAL_TEMP_FRACTION;
    assign lo_ofs[CH_REMOTE1] = OFS_REMOTE_ONE_SIGNED_FRACTION;
    assign lo_ofs[CH_REMOTE2] = OFS_REMOTE_TWO_SIGNED_FRACTION;

    // The local channel has no filter, so its extra bits always mask off.
    assign filt_vec = {remote_filt_on, 1'b0};

    // Own registers: alarm limit is read/write, status is read only.
    assign hit_limit = (reg_addr == OFS_ALARM_LIMIT);
    assign hit_status = (reg_addr == OFS_READOUT_STATUS);
    assign wr_limit = reg_wr && hit_limit;
    assign nxt_limit = wr_limit ? reg_wdata : limit_ff;

    // Status shows the alarm, which channels hold a fraction, and filter state.
    assign status_byte = {2'b00, remote_filt_on, held_vec, alarm_ff};

    // ******************************************************************
    // Channels
    // ******************************************************************

    // Host discipline of reading the integer byte first is the host's; each
    // read event below is decoded on the cycle the strobe is seen.
    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
            assign rd_hi[ch] = reg_rd && (reg_addr == hi_ofs[ch]);
            assign rd_lo[ch] = reg_rd && (reg_addr == lo_ofs[ch]);

            tvr_chan u_chan (
                .clk_sys(clk_sys),
                .reset(reset),
                .ce(ce),
                .conv_valid(conv_valid[ch]),
                .conv_int(conv_int[ch]),
                .conv_frac(conv_frac[ch]),
                .filt_on(filt_vec[ch]),
                .rd_hi(rd_hi[ch]),
                .rd_lo(rd_lo[ch]),
                .hi_byte(hi_bytes[ch]),
                .lo_byte(lo_bytes[ch]),
                .held(held_vec[ch])
            );
        end
    endgenerate

    // ******************************************************************
    // Over-temperature decision
    // ******************************************************************

    // The local integer byte is compared against the software limit.
    tvr_alarm u_alarm (
        .clk_sys(clk_sys),
        .reset(reset),
        .ce(ce),
        .local_int(hi_bytes[CH_LOCAL]),
        .limit(limit_ff),
        .over(alarm_q)
    );

    // ******************************************************************
    // Read data selection
    // ******************************************************************

    // Unmapped addresses answer with zero; data appears only after a read.
    always_comb begin
        nxt_rdata = UNMAPPED_DATA;
        if (reg_rd) begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                if (rd_hi[ch]) begin
                    nxt_rdata = hi_bytes[ch];
                end
                if (rd_lo[ch]) begin
                    nxt_rdata = lo_bytes[ch];
                end
            end
            if (hit_limit) begin
                nxt_rdata = limit_ff;
            end
            if (hit_status) begin
                nxt_rdata = status_byte;
            end
        end
    end

    // ******************************************************************
    // Registers
    // ******************************************************************

    // Read data register; cleared in idle cycles with the enable high, held while the enable is low.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_ff <= UNMAPPED_DATA;
        end else if (ce) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Alarm limit; writes to all value registers are simply ignored.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            limit_ff <= RST_ALARM_LIMIT;
        end else if (ce) begin
            limit_ff <= nxt_limit;
        end
    end

    // Output copy of the alarm, so the port comes from a local flip-flop.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            alarm_ff <= 1'b0;
        end else if (ce) begin
            alarm_ff <= alarm_q;
        end
    end

    assign reg_rdata = rdata_ff;
    assign local_alarm = alarm_ff;

endmodule

//--- tvr_pkg.sv
// Constants shared by the temperature value readout block.
// Assumes an 8-bit command space reached over a plain register port.
package tvr_pkg;

    // ******************************************************************
    // Channel layout
    // ******************************************************************
    localparam int NUM_CH = 3;
    localparam int CH_LOCAL = 0;
    localparam int CH_REMOTE1 = 1;
    localparam int CH_REMOTE2 = 2;
    localparam int INT_W = 8;
    localparam int FRAC_W = 5;
    localparam int BASE_FRAC_W = 3;

    // ******************************************************************
    // Command offsets
    // ******************************************************************
    localparam logic [7:0] OFS_LOCAL_TEMP_INTEGER = 8'h10;
    localparam logic [7:0] OFS_REMOTE_ONE_SIGNED_INTEGER = 8'h11;
    localparam logic [7:0] OFS_REMOTE_TWO_SIGNED_INTEGER = 8'h12;
    localparam logic [7:0] OFS_LOCAL_TEMP_FRACTION = 8'h20;
    localparam logic [7:0] OFS_REMOTE_ONE_SIGNED_FRACTION = 8'h21;
    localparam logic [7:0] OFS_REMOTE_TWO_SIGNED_FRACTION = 8'h22;
    localparam logic [7:0] OFS_ALARM_LIMIT = 8'h60;
    localparam logic [7:0] OFS_READOUT_STATUS = 8'h61;

    // ******************************************************************
    // Reset values and status fields
    // ******************************************************************
    localparam logic [7:0] RST_ALARM_LIMIT = 8'h50;
    localparam logic [7:0] RST_RESULT_INT = 8'h00;
    localparam logic [4:0] RST_RESULT_FRAC = 5'h00;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    localparam int STS_ALARM_BIT = 0;
    localparam int STS_HELD_LSB = 1;
    localparam int STS_FILT_LSB = 4;

endpackage

//--- tvr_chan.sv
// One temperature channel: live result, fraction hold latch and byte formatting.
// Assumes read pulses are single-cycle and never both high at once.
`timescale 1ns/100ps

module tvr_chan
    import tvr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    // Conversion results
    input wire logic conv_valid,
    input wire logic [INT_W-1:0] conv_int,
    input wire logic [FRAC_W-1:0] conv_frac,
    input wire logic filt_on,
    // Read events
    input wire logic rd_hi,
    input wire logic rd_lo,
    // Formatted bytes and hold state
    output logic [7:0] hi_byte,
    output logic [7:0] lo_byte,
    output logic held
);

    logic [INT_W-1:0] int_ff;
    logic [FRAC_W-1:0] frac_ff;
    logic [7:0] hold_ff;
    logic held_ff;
    logic [FRAC_W-1:0] frac_mask;
    logic [7:0] live_lo;
    logic [7:0] nxt_hold;
    logic nxt_held;

    // Filter bits show only while the filter is on; bits below read zero.
    assign frac_mask = filt_on ? {FRAC_W{1'b1}} : {{BASE_FRAC_W{1'b1}}, {(FRAC_W-BASE_FRAC_W){1'b0}}};
    assign live_lo = {frac_ff & frac_mask, {(8-FRAC_W){1'b0}}};
    assign hi_byte = int_ff;

    // A high read always recaptures; a low read releases the hold.
    assign nxt_hold = rd_hi ? live_lo : hold_ff;
    assign nxt_held = rd_hi ? 1'b1 : (rd_lo ? 1'b0 : held_ff);
    assign lo_byte = held_ff ? hold_ff : live_lo;
    assign held = held_ff;

    // Conversions keep landing here even while the low byte is held.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            int_ff <= RST_RESULT_INT;
            frac_ff <= RST_RESULT_FRAC;
        end else if (ce && conv_valid) begin
            int_ff <= conv_int;
            frac_ff <= conv_frac;
        end
    end

    // Hold latch; a high read in the update cycle sees the older result, matching the byte returned.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hold_ff <= 8'h00;
            held_ff <= 1'b0;
        end else if (ce) begin
            hold_ff <= nxt_hold;
            held_ff <= nxt_held;
        end
    end

endmodule

//--- tvr_alarm.sv
// Local over-temperature decision from the local integer value.
// Assumes the limit comes from a register in the same clock domain.
`timescale 1ns/100ps

module tvr_alarm
    import tvr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    // Compare inputs
    input wire logic [INT_W-1:0] local_int,
    input wire logic [7:0] limit,
    // Decision
    output logic over
);

    logic over_ff;
    logic nxt_over;

    // Signed compare: a negative reading never trips a positive limit.
    assign nxt_over = $signed(local_int) > $signed(limit);
    assign over = over_ff;

    // Registered so the decision is glitch free.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            over_ff <= 1'b0;
        end else if (ce) begin
            over_ff <= nxt_over;
        end
    end

endmodule

//--- tvr_asserts.sv
// Port checker for the temperature value readout.
// Assumes it is bound to tvr_readout; checks count only cycles with the enable high.
`timescale 1ns/100ps
module tvr_asserts
    import tvr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Conversions and alarm
    input wire logic [NUM_CH-1:0] conv_valid,
    input wire logic [NUM_CH-1:0][INT_W-1:0] conv_int,
    input wire logic [NUM_CH-1:0][FRAC_W-1:0] conv_frac,
    input wire logic [1:0] remote_filt_on,
    input wire logic local_alarm
);
    // ****
    // Shadow state
    // ****
    logic [7:0] li_ff [4];
    logic [4:0] lf_ff [4];
    logic [7:0] hv_ff [4];
    logic [3:0] hd_ff;
    logic [7:0] lim_ff;
    wire [1:0] ch = reg_addr[1:0];
    wire is_int = reg_addr[7:4] == 4'h1 && ch != 2'd3;
    wire is_frac = reg_addr[7:4] == 4'h2 && ch != 2'd3;
    wire alarm_c = $signed(li_ff[0]) > $signed(lim_ff);

    // Fraction byte as formed; the filter only matters on the remote channels.
    function automatic logic [7:0] fmt_b(input logic [1:0] c, input logic [4:0] f, input logic [1:0] fo);
        fmt_b = {f[4:2], (c != 2'd0 && fo[c[1]]) ? f[1:0] : 2'b00, 3'b000};
    endfunction

    wire [7:0] exp_frac = hd_ff[ch] ? hv_ff[ch] : fmt_b(ch, lf_ff[ch], remote_filt_on);

    // The shadow follows reads with the old result pair, like the design.
    always_ff @(posedge clk_sys) begin
        if (reset && ce) begin
            lim_ff <= RST_ALARM_LIMIT;
            hd_ff <= '0;
            li_ff <= '{default: 8'h00};
            lf_ff <= '{default: 5'h00};
        end else if (ce) begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (conv_valid[c]) begin
                    li_ff[c] <= conv_int[c];
                    lf_ff[c] <= conv_frac[c];
                end
            end
            if (reg_wr && reg_addr == OFS_ALARM_LIMIT) begin
                lim_ff <= reg_wdata;
            end
            if (reg_rd && is_int) begin
                hd_ff[ch] <= 1'b1;
                hv_ff[ch] <= fmt_b(ch, lf_ff[ch], remote_filt_on);
            end
            if (reg_rd && is_frac) begin
                hd_ff[ch] <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_loc_int; ce && reg_rd && is_int && ch == 2'd0 |=> reg_rdata == $past(li_ff[0]); endproperty
    a_loc_int: assert property (p_loc_int) else $error("local integer byte wrong");
    property p_rem_int; ce && reg_rd && is_int && ch != 2'd0 |=> reg_rdata == $past(li_ff[ch]); endproperty
    a_rem_int: assert property (p_rem_int) else $error("remote integer byte wrong");
    property p_loc_frac; ce && reg_rd && is_frac && ch == 2'd0 |=> reg_rdata == $past(exp_frac); endproperty
    a_loc_frac: assert property (p_loc_frac) else $error("local fraction byte wrong");
    property p_rem_frac; ce && reg_rd && is_frac && ch != 2'd0 |=> reg_rdata == $past(exp_frac); endproperty
    a_rem_frac: assert property (p_rem_frac) else $error("remote fraction byte wrong");
    property p_loc_zero; ce && reg_rd && is_frac && ch == 2'd0 |=> reg_rdata[4:0] == 5'h00; endproperty
    a_loc_zero: assert property (p_loc_zero) else $error("local unused bits set");
    property p_rem_zero; ce && reg_rd && is_frac && ch != 2'd0 |=> reg_rdata[2:0] == 3'h0; endproperty
    a_rem_zero: assert property (p_rem_zero) else $error("remote unused bits set");
    property p_filt_off;
        ce && reg_rd && is_frac && ch != 2'd0 && !hd_ff[ch] && !remote_filt_on[ch[1]] |=> reg_rdata[4:3] == 2'b00;
    endproperty
    a_filt_off: assert property (p_filt_off) else $error("filter bits shown with filter off");
    property p_alarm;
        ce && $past(ce) && $past(ce, 2) && !$past(reset, 2) |-> local_alarm == $past(alarm_c, 2);
    endproperty
    a_alarm: assert property (p_alarm) else $error("local alarm does not follow value");
endmodule

bind tvr_readout tvr_asserts u_chk (.clk_sys(clk_sys), .reset(reset), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_valid(conv_valid),
    .conv_int(conv_int), .conv_frac(conv_frac), .remote_filt_on(remote_filt_on), .local_alarm(local_alarm));

//--- tvr_conv_model.sv
// Conversion engine model feeding result pulses to the readout.
// Assumes one-cycle requests from the bench.
`timescale 1ns/100ps
module tvr_conv_model
    import tvr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Bench requests
    input wire logic [NUM_CH-1:0] req,
    input wire logic [INT_W-1:0] req_int,
    input wire logic [FRAC_W-1:0] req_frac,
    // Result side
    output logic [NUM_CH-1:0] conv_valid,
    output logic [NUM_CH-1:0][INT_W-1:0] conv_int,
    output logic [NUM_CH-1:0][FRAC_W-1:0] conv_frac
);
    // Results stand only with their pulse; otherwise the lines toggle, so sampling off the pulse shows up.
    always_ff @(posedge clk_sys) begin
        conv_valid <= reset ? '0 : req;
        for (int c = 0; c < NUM_CH; c++) begin
            conv_int[c] <= req[c] ? req_int : ~conv_int[c];
            conv_frac[c] <= req[c] ? req_frac : ~conv_frac[c];
        end
    end
endmodule

//--- tb_top.sv
// Self-checking bench for the temperature value readout.
// Assumes the package, conversion model and checker are compiled first.
`timescale 1ns/100ps
module tb_top;
    import tvr_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ce = 1'b1;
    logic [7:0] reg_rdata;
    logic [1:0] filt = 2'b00;
    logic [NUM_CH-1:0] req = '0;
    logic [7:0] r_int = 8'h00;
    logic [4:0] r_frac = 5'h00;
    logic [NUM_CH-1:0] cv;
    logic [NUM_CH-1:0][INT_W-1:0] ci;
    logic [NUM_CH-1:0][FRAC_W-1:0] cf;
    logic alarm;
    logic pend = 1'b0;
    logic [7:0] li [4] = '{default: 8'h00};
    logic [4:0] lf [4] = '{default: 5'h00};
    logic [7:0] hv [4];
    logic [3:0] hd = '0;
    logic [7:0] lim = RST_ALARM_LIMIT;
    logic [7:0] exp_q [$];
    int error_cnt = 0;
    int cmp_count = 0;
    int seed = 16;

    always #2.5 clk_sys = ~clk_sys;

    tvr_readout uut (.clk_sys(clk_sys), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_valid(cv), .conv_int(ci),
        .conv_frac(cf), .remote_filt_on(filt), .local_alarm(alarm));
    tvr_conv_model u_conv (.clk_sys(clk_sys), .reset(reset), .req(req), .req_int(r_int), .req_frac(r_frac),
        .conv_valid(cv), .conv_int(ci), .conv_frac(cf));

    // ****
    // Checking
    // ****
    task automatic check(input logic [7:0] got, input logic [7:0] want);
        cmp_count++;
        if (got !== want) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    // Read data stand only in the cycle after the strobe, so compare exactly there.
    // A strobe seen while the enable is low is lost, so it expects no answer.
    always @(posedge clk_sys) begin
        if (pend) check(reg_rdata, exp_q.pop_front());
        pend <= reg_rd && ce;
    end

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****
    // Host and engine tasks
    // ****
    function automatic logic [7:0] fmt(input int c, input logic [4:0] f);
        fmt = {f[4:2], (c != 0 && filt[c-1]) ? f[1:0] : 2'b00, 3'b000};
    endfunction

    // Integer reads latch the fraction as formed now; fraction reads release it.
    task automatic rd(input logic [7:0] a);
        int c;
        logic [7:0] e;
        c = a[1:0];
        e = 8'h00;
        if (a[7:4] == 4'h1) begin
            e = li[c];
            hd[c] = 1'b1;
            hv[c] = fmt(c, lf[c]);
        end else if (a[7:4] == 4'h2) begin
            e = hd[c] ? hv[c] : fmt(c, lf[c]);
            hd[c] = 1'b0;
        end else if (a == OFS_ALARM_LIMIT) begin
            e = lim;
        end else if (a == OFS_READOUT_STATUS) begin
            e = {2'b00, filt, hd[2:0], $signed(li[0]) > $signed(lim)};
        end
        exp_q.push_back(e);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == OFS_ALARM_LIMIT) lim = d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
    endtask

    // A read strobed while the enable is low must change nothing.
    task automatic freeze(input logic [7:0] a);
        ce <= 1'b0;
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        @(posedge clk_sys);
        ce <= 1'b1;
    endtask

    // The result is live two edges after the request.
    task automatic conv(input int c, input logic [7:0] i, input logic [4:0] f);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        req <= 3'(1 << c);
        r_int <= i;
        r_frac <= f;
        @(posedge clk_sys);
        req <= '0;
        @(posedge clk_sys);
        li[c] = i;
        lf[c] = f;
    endtask

    initial begin
        #(5000 * 5);
        error_cnt++;
        give_verdict();
    end

    // ****
    // Scenarios
    // ****
    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        for (int k = 0; k < 6; k++) begin
            filt <= (k > 2) ? 2'b11 : 2'b00;
            conv(k % 3, 8'($random(seed)), 5'($random(seed)));
            rd(8'h10 + 8'(k % 3));
            rd(8'h20 + 8'(k % 3));
            rd(8'h20 + 8'(k % 3));
        end
        $display("formats done");
        conv(1, 8'h19, 5'h1f);
        rd(8'h11);
        conv(1, 8'he7, 5'h0a);
        rd(8'h21);
        rd(8'h21);
        rd(8'h11);
        conv(1, 8'h80, 5'h15);
        rd(8'h11);
        filt <= 2'b00;
        rd(8'h21);
        rd(8'h10);
        rd(8'h11);
        rd(8'h12);
        rd(8'h22);
        rd(8'h21);
        rd(8'h20);
        rd(8'h33);
        wr(8'h10, 8'h55);
        rd(8'h10);
        rd(8'h12);
        freeze(8'h22);
        rd(8'h22);
        $display("hold done");
        for (int k = 0; k < 4; k++) begin
            wr(OFS_ALARM_LIMIT, k[1] ? 8'h80 : 8'h50);
            conv(0, k[0] ? 8'h51 : (k[1] ? 8'h81 : 8'h50), 5'h00);
            repeat (2) @(posedge clk_sys);
            #1 check({7'h00, alarm}, {7'h00, $signed(li[0]) > $signed(lim)});
            @(posedge clk_sys);
        end
        rd(OFS_ALARM_LIMIT);
        rd(OFS_READOUT_STATUS);
        $display("alarm done");
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        repeat (3) @(posedge clk_sys);
        give_verdict();
    end
endmodule
